/* File: include/omfl_params.svh */
// Constants for the OR, move and pointer-load decode block
// ---------------------------------------------------------------------------
// Notes on behaviour
// - The literal OR ORs the accumulator with the low byte and keeps it in the accumulator.
// - The file OR ORs the accumulator with a file register; bit 9 picks destination, bit 8 bank.
// - A destination bit of 0 writes the accumulator, 1 writes the file register back.
// - A bank bit of 0 uses the access bank, 1 forms the address from the bank select value.
// - Bank bit 0 with extended mode on and a field up to 5Fh uses the indexed offset address.
// - The register move copies a file register to the accumulator or back to itself in one instruction cycle.
// - Both ORs and the move set negative and zero; the pointer load leaves flags alone.
// - The pointer load puts a 12-bit literal into pointer 0 to 2 over two words and cycles.
// - A move written without a destination carries destination bit 1, a write-back.
// ---------------------------------------------------------------------------
`ifndef OMFL_PARAMS_SVH
`define OMFL_PARAMS_SVH

// ---------------------------------------------------------------------------
// Opcode patterns
// ---------------------------------------------------------------------------
`define OMFL_OPC_ORL      8'h09
`define OMFL_OPC_OR_FILE  6'h04
`define OMFL_OPC_MOVE_FILE 6'h14
`define OMFL_OPC_PTR_HI   10'h3B8
`define OMFL_SEL_NONE     2'h3

// ---------------------------------------------------------------------------
// Addressing
// ---------------------------------------------------------------------------
`define OMFL_IDX_LIMIT    8'h5F
`define OMFL_ACC_SPLIT    8'h60
`define OMFL_ACC_LO_BANK  4'h0
`define OMFL_ACC_HI_BANK  4'hF
`define OMFL_NIB_ZERO     4'h0

// ---------------------------------------------------------------------------
// Register port map and fields
// ---------------------------------------------------------------------------
`define OMFL_REG_CTRL     4'h0
`define OMFL_REG_ACC      4'h1
`define OMFL_REG_BANK     4'h2
`define OMFL_REG_STATUS   4'h3
`define OMFL_REG_PTR0     4'h4
`define OMFL_REG_PTR1     4'h5
`define OMFL_REG_PTR2     4'h6
`define OMFL_ST_Z_BIT     0
`define OMFL_ST_N_BIT     1
`define OMFL_CTRL_EXT_BIT 0

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define OMFL_RST_BYTE     8'h00
`define OMFL_RST_NIB      4'h0
`define OMFL_RST_PTR      12'h000
`define OMFL_RST_ADDR     12'h000
`define OMFL_RST_WORD     16'h0000
`define OMFL_RST_IR       16'h0000

`endif

/* File: include/omfl_pkg.sv */
// Types shared by the decode block and its helpers
package omfl_pkg;

    // -----------------------------------------------------------------------
    // Phase and operation types
    // -----------------------------------------------------------------------
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} omfl_phase_e;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_ORL,
        OP_OR_FILE,
        OP_MOVE_FILE,
        OP_PTR_HI,
        OP_PTR_LO
    } omfl_op_e;

endpackage : omfl_pkg

/* File: logic/omfl_phase_seq.sv */
// Four-phase instruction cycle sequencer
`timescale 1ns/1ps
module omfl_phase_seq (
    input  wire logic            clk_sys_in, // System clock
    input  wire logic            rst_b_in,   // Async reset, active low
    output omfl_pkg::omfl_phase_e phase_out  // Current phase
);

    omfl_pkg::omfl_phase_e phase_ff;
    omfl_pkg::omfl_phase_e nxt_phase;

    // Fixed rotation through the four phases
    always_comb
    begin
        case (phase_ff)
            omfl_pkg::PH_Q1: nxt_phase = omfl_pkg::PH_Q2;
            omfl_pkg::PH_Q2: nxt_phase = omfl_pkg::PH_Q3;
            omfl_pkg::PH_Q3: nxt_phase = omfl_pkg::PH_Q4;
            default:         nxt_phase = omfl_pkg::PH_Q1;
        endcase
    end

    // Phase register
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            phase_ff <= omfl_pkg::PH_Q1;
        else
            phase_ff <= nxt_phase;
    end

    assign phase_out = phase_ff;

endmodule : omfl_phase_seq

/* File: logic/omfl_addr_form.sv */
// Data address former: access bank, banked and indexed offset modes
`timescale 1ns/1ps
`include "omfl_params.svh"
module omfl_addr_form (
    input  wire logic        bank_bit_in, // 0 access bank, 1 banked
    input  wire logic [7:0]  field_in,    // Register field of the word
    input  wire logic [3:0]  bank_in,     // Bank select value
    input  wire logic [11:0] ptr2_in,     // Base pointer for indexed mode
    input  wire logic        ext_en_in,   // Extended set enabled
    output logic      [11:0] addr_out,    // Formed data address
    output logic             indexed_out  // Indexed mode chosen
);

    // Mode selection
    wire       idx_sel   = !bank_bit_in && ext_en_in
                           && (field_in <= `OMFL_IDX_LIMIT);
    wire       acc_upper = field_in >= `OMFL_ACC_SPLIT;
    wire [3:0] acc_page  = acc_upper ? `OMFL_ACC_HI_BANK
                                     : `OMFL_ACC_LO_BANK;

    // Address mux; indexed wins over the plain access bank
    assign addr_out    = idx_sel     ? ptr2_in + {`OMFL_NIB_ZERO, field_in}
                       : bank_bit_in ? {bank_in, field_in}
                       : {acc_page, field_in};
    assign indexed_out = idx_sel;

endmodule : omfl_addr_form

/* File: logic/omfl_core.sv */
// Decode and execute for literal OR, file OR, file move and pointer load
`timescale 1ns/1ps
`include "omfl_params.svh"
module omfl_core (
    input  wire logic        clk_sys_in,     // System clock, 250 MHz
    input  wire logic        rst_b_in,       // Async reset, active low
    input  wire logic [15:0] instr_in,       // Program word from fetch
    input  wire logic        instr_valid_in, // Program word present
    output logic             instr_ack_out,  // Word taken, one cycle
    output logic      [11:0] dmem_addr_out,  // Data memory address
    output logic             dmem_rd_out,    // Data memory read strobe
    input  wire logic [7:0]  dmem_rdata_in,  // Read data, cycle after
    output logic             dmem_wr_out,    // Data memory write strobe
    output logic      [7:0]  dmem_wdata_out, // Data memory write data
    input  wire logic [3:0]  reg_addr_in,    // Register port address
    input  wire logic [15:0] reg_wdata_in,   // Register port write data
    input  wire logic        reg_wr_in,      // Register write strobe
    input  wire logic        reg_rd_in,      // Register read strobe
    output logic      [15:0] reg_rdata_out   // Read data, cycle after
);

    // -----------------------------------------------------------------------
    // Helper functions
    // -----------------------------------------------------------------------

    // Word classification; a pending pointer load claims the next word
    function automatic omfl_pkg::omfl_op_e decode_op(
        input logic [15:0] word,
        input logic        pend
    );
        decode_op = omfl_pkg::OP_NONE;
        if (pend)
            decode_op = omfl_pkg::OP_PTR_LO;
        else if (word[15:8] == `OMFL_OPC_ORL)
            decode_op = omfl_pkg::OP_ORL;
        else if (word[15:10] == `OMFL_OPC_OR_FILE)
            decode_op = omfl_pkg::OP_OR_FILE;
        else if (word[15:10] == `OMFL_OPC_MOVE_FILE)
            decode_op = omfl_pkg::OP_MOVE_FILE;
        else if (word[15:6] == `OMFL_OPC_PTR_HI)
            decode_op = omfl_pkg::OP_PTR_HI;
    endfunction : decode_op

    // Operations that touch a file register
    function automatic logic uses_file(input omfl_pkg::omfl_op_e op);
        uses_file = (op == omfl_pkg::OP_OR_FILE)
                    || (op == omfl_pkg::OP_MOVE_FILE);
    endfunction : uses_file

    // Operations that update negative and zero
    function automatic logic sets_flags(input omfl_pkg::omfl_op_e op);
        sets_flags = uses_file(op) || (op == omfl_pkg::OP_ORL);
    endfunction : sets_flags

    // -----------------------------------------------------------------------
    // State
    // -----------------------------------------------------------------------
    omfl_pkg::omfl_phase_e phase;
    omfl_pkg::omfl_op_e    op_ff;
    logic [15:0] ir_ff;
    logic [7:0]  acc_ff;
    logic [3:0]  bank_ff;
    logic [11:0] ptr_ff [0:2];
    logic        ext_en_ff;
    logic        zero_ff;
    logic        neg_ff;
    logic        ptr_pend_ff;
    logic [1:0]  ptr_sel_ff;
    logic [7:0]  res_ff;
    logic [11:0] form_addr;
    logic        form_idx;
    logic [15:0] rd_mux;

    // -----------------------------------------------------------------------
    // Phase sequencer and address former
    // -----------------------------------------------------------------------
    omfl_phase_seq u_phase (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .phase_out  (phase)
    );

    omfl_addr_form u_addr (
        .bank_bit_in (instr_in[8]),
        .field_in    (instr_in[7:0]),
        .bank_in     (bank_ff),
        .ptr2_in     (ptr_ff[2]),
        .ext_en_in   (ext_en_ff),
        .addr_out    (form_addr),
        .indexed_out (form_idx)
    );

    // -----------------------------------------------------------------------
    // Decode and execute terms
    // -----------------------------------------------------------------------

    // A word is only taken in the decode phase
    wire in_q1     = phase == omfl_pkg::PH_Q1;
    wire in_q2     = phase == omfl_pkg::PH_Q2;
    wire in_q3     = phase == omfl_pkg::PH_Q3;
    wire in_q4     = phase == omfl_pkg::PH_Q4;
    wire take_word = in_q1 && instr_valid_in;
    wire omfl_pkg::omfl_op_e nxt_op = take_word
        ? decode_op(instr_in, ptr_pend_ff) : omfl_pkg::OP_NONE;
    wire dest_file = ir_ff[9];
    wire [7:0] nxt_res = (op_ff == omfl_pkg::OP_ORL)
                       ? acc_ff | ir_ff[7:0]
                       : (op_ff == omfl_pkg::OP_OR_FILE)
                       ? acc_ff | dmem_rdata_in
                       : dmem_rdata_in;
    wire acc_load  = in_q4 && ((op_ff == omfl_pkg::OP_ORL)
                     || (uses_file(op_ff) && !dest_file));
    wire file_wr   = in_q3 && uses_file(op_ff) && dest_file;
    wire bus_wr_acc  = reg_wr_in && (reg_addr_in == `OMFL_REG_ACC);
    wire bus_wr_bank = reg_wr_in && (reg_addr_in == `OMFL_REG_BANK);
    wire bus_wr_ctrl = reg_wr_in && (reg_addr_in == `OMFL_REG_CTRL);
    wire hi_write  = in_q4 && (op_ff == omfl_pkg::OP_PTR_HI);
    wire lo_write  = in_q4 && (op_ff == omfl_pkg::OP_PTR_LO);

    // -----------------------------------------------------------------------
    // Decode phase: latch word, address and read strobe
    // -----------------------------------------------------------------------

    // Address is held from decode through write so read and write match
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            op_ff         <= omfl_pkg::OP_NONE;
            ir_ff         <= `OMFL_RST_IR;
            dmem_addr_out <= `OMFL_RST_ADDR;
        end
        else if (in_q1)
        begin
            op_ff <= nxt_op;
            ir_ff <= instr_in;
            if (uses_file(nxt_op))
                dmem_addr_out <= form_addr;
        end
    end

    // Read strobe for the operand phase, acknowledge for the fetch side
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            dmem_rd_out   <= 1'b0;
            instr_ack_out <= 1'b0;
        end
        else
        begin
            dmem_rd_out   <= in_q1 && uses_file(nxt_op);
            instr_ack_out <= take_word;
        end
    end

    // -----------------------------------------------------------------------
    // Process phase: result and file write-back strobe
    // -----------------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            res_ff         <= `OMFL_RST_BYTE;
            dmem_wr_out    <= 1'b0;
            dmem_wdata_out <= `OMFL_RST_BYTE;
        end
        else
        begin
            if (in_q3)
            begin
                res_ff         <= nxt_res;
                dmem_wdata_out <= nxt_res;
            end
            dmem_wr_out <= file_wr;
        end
    end

    // -----------------------------------------------------------------------
    // Write phase: accumulator and flags
    // -----------------------------------------------------------------------

    // Instruction write wins over a port write in the same cycle
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            acc_ff <= `OMFL_RST_BYTE;
        else if (acc_load)
            acc_ff <= res_ff;
        else if (bus_wr_acc)
            acc_ff <= reg_wdata_in[7:0];
    end

    // Pointer loads never reach this process, so flags hold
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            zero_ff <= 1'b0;
            neg_ff  <= 1'b0;
        end
        else if (in_q4 && sets_flags(op_ff))
        begin
            zero_ff <= res_ff == `OMFL_RST_BYTE;
            neg_ff  <= res_ff[7];
        end
    end

    // -----------------------------------------------------------------------
    // Pointer load over two cycles
    // -----------------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ptr_pend_ff <= 1'b0;
            ptr_sel_ff  <= `OMFL_SEL_NONE;
        end
        else if (hi_write)
        begin
            ptr_pend_ff <= 1'b1;
            ptr_sel_ff  <= ir_ff[5:4];
        end
        else if (lo_write)
            ptr_pend_ff <= 1'b0;
    end

    // Selector 3 names no pointer and writes nothing
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            for (int i = 0; i < 3; i++)
                ptr_ff[i] <= `OMFL_RST_PTR;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (hi_write && (ir_ff[5:4] == 2'(i)))
                    ptr_ff[i][11:8] <= ir_ff[3:0];
                else if (lo_write && (ptr_sel_ff == 2'(i)))
                    ptr_ff[i][7:0] <= ir_ff[7:0];
            end
        end
    end

    // -----------------------------------------------------------------------
    // Register port
    // -----------------------------------------------------------------------

    // Software-written steering: bank select and extended mode
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            bank_ff   <= `OMFL_RST_NIB;
            ext_en_ff <= 1'b0;
        end
        else
        begin
            if (bus_wr_bank)
                bank_ff <= reg_wdata_in[3:0];
            if (bus_wr_ctrl)
                ext_en_ff <= reg_wdata_in[`OMFL_CTRL_EXT_BIT];
        end
    end

    // Read decode; unmapped offsets read zero
    always_comb
    begin
        rd_mux = `OMFL_RST_WORD;
        if (reg_addr_in == `OMFL_REG_CTRL)
            rd_mux[`OMFL_CTRL_EXT_BIT] = ext_en_ff;
        else if (reg_addr_in == `OMFL_REG_ACC)
            rd_mux[7:0] = acc_ff;
        else if (reg_addr_in == `OMFL_REG_BANK)
            rd_mux[3:0] = bank_ff;
        else if (reg_addr_in == `OMFL_REG_STATUS)
        begin
            rd_mux[`OMFL_ST_Z_BIT] = zero_ff;
            rd_mux[`OMFL_ST_N_BIT] = neg_ff;
        end
        else if (reg_addr_in == `OMFL_REG_PTR0)
            rd_mux[11:0] = ptr_ff[0];
        else if (reg_addr_in == `OMFL_REG_PTR1)
            rd_mux[11:0] = ptr_ff[1];
        else if (reg_addr_in == `OMFL_REG_PTR2)
            rd_mux[11:0] = ptr_ff[2];
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            reg_rdata_out <= `OMFL_RST_WORD;
        else
            reg_rdata_out <= reg_rd_in ? rd_mux : `OMFL_RST_WORD;
    end

    // -----------------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_b_in);

    phase_order_a: assert property (
        in_q1 |=> in_q2 ##1 in_q3 ##1 in_q4)
        else $error("phase order broken");

    lit_or_a: assert property (
        (in_q4 && op_ff == omfl_pkg::OP_ORL)
        |=> acc_ff == ($past(acc_ff) | $past(ir_ff[7:0])))
        else $error("literal OR result wrong");

    file_or_wb_a: assert property (
        (in_q3 && op_ff == omfl_pkg::OP_OR_FILE && dest_file)
        |=> dmem_wr_out
            && dmem_wdata_out == ($past(acc_ff) | $past(dmem_rdata_in)))
        else $error("file OR write-back wrong");

    dest_acc_a: assert property (
        (in_q3 && uses_file(op_ff) && !dest_file)
        |=> !dmem_wr_out ##1 acc_ff == $past(res_ff))
        else $error("accumulator destination wrong");

    bank_addr_a: assert property (
        (in_q2 && uses_file(op_ff) && ir_ff[8])
        |-> dmem_addr_out == {$past(bank_ff), ir_ff[7:0]})
        else $error("banked address wrong");

    indexed_addr_a: assert property (
        (in_q2 && uses_file(op_ff) && !ir_ff[8] && $past(ext_en_ff)
         && ir_ff[7:0] <= `OMFL_IDX_LIMIT)
        |-> dmem_addr_out == $past(ptr_ff[2]) + {`OMFL_NIB_ZERO, ir_ff[7:0]})
        else $error("indexed address wrong");

    move_copy_a: assert property (
        (in_q3 && op_ff == omfl_pkg::OP_MOVE_FILE && dest_file)
        |=> dmem_wdata_out == $past(dmem_rdata_in))
        else $error("move data wrong");

    flag_upd_a: assert property (
        (in_q4 && sets_flags(op_ff))
        |=> zero_ff == (res_ff == 8'h00) && neg_ff == res_ff[7])
        else $error("flags not updated");

    ptr_flags_a: assert property (
        (in_q4 && !sets_flags(op_ff)) |=> $stable(zero_ff) && $stable(neg_ff))
        else $error("flags changed by pointer load");

    ptr_high_a: assert property (
        (hi_write && ir_ff[5:4] != `OMFL_SEL_NONE)
        |=> ptr_ff[ir_ff[5:4]][11:8] == ir_ff[3:0] && ptr_pend_ff)
        else $error("pointer high nibble wrong");

    ptr_low_a: assert property (
        (lo_write && ptr_sel_ff != `OMFL_SEL_NONE)
        |=> ptr_ff[ptr_sel_ff][7:0] == $past(ir_ff[7:0]) && !ptr_pend_ff)
        else $error("pointer low byte wrong");

endmodule : omfl_core

/* File: sim/omfl_dmem_model.sv */
// Behavioural banked data memory seen from the decode block
`timescale 1ns/1ps
module omfl_dmem_model (
    input  wire logic        clk_sys_in, // System clock
    input  wire logic [11:0] addr_in,    // Data address
    input  wire logic        rd_in,      // Read strobe
    input  wire logic        wr_in,      // Write strobe
    input  wire logic [7:0]  wdata_in,   // Write data
    output logic      [7:0]  rdata_out   // Read data, cycle after strobe
);
    logic [7:0] mem [0:4095];

    // Known fill pattern so the bench can predict every byte
    initial
    begin
        for (int i = 0; i < 4096; i++)
            mem[i] = 8'(i) ^ 8'h3C;
        rdata_out = 8'h00;
    end

    // Data only in the cycle after a read; otherwise it toggles so
    // nothing stale can pass for a good read
    always @(posedge clk_sys_in)
    begin
        rdata_out <= rd_in ? mem[addr_in] : ~rdata_out;
        if (wr_in)
            mem[addr_in] <= wdata_in;
    end
endmodule : omfl_dmem_model

/* File: sim/or_move_fsr_load_decode_tb.sv */
// Self-checking bench for the OR, move and pointer-load decode block
`timescale 1ns/1ps
module or_move_fsr_load_decode_tb;
    logic        clk = 1'b0, rst_b = 1'b0, valid = 1'b0, ack, rd, wr;
    logic        reg_wr = 1'b0, reg_rd = 1'b0;
    logic [15:0] instr = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
    logic [3:0]  reg_addr = 4'h0;
    logic [11:0] addr;
    logic [7:0]  rdata, wdata;
    int          error_cnt = 0, samples_checked = 0, wr_cnt = 0;

    // ---------------------------------------------------------------
    // Design and data memory
    // ---------------------------------------------------------------
    omfl_core dut (.clk_sys_in(clk), .rst_b_in(rst_b), .instr_in(instr),
        .instr_valid_in(valid), .instr_ack_out(ack), .dmem_addr_out(addr),
        .dmem_rd_out(rd), .dmem_rdata_in(rdata), .dmem_wr_out(wr),
        .dmem_wdata_out(wdata), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata));
    omfl_dmem_model m (.clk_sys_in(clk), .addr_in(addr), .rd_in(rd),
        .wr_in(wr), .wdata_in(wdata), .rdata_out(rdata));

    // Clock and write-strobe tally
    initial
    begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
        if (wr === 1'b1)
            wr_cnt++;

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic reg_write(logic [3:0] a, logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(string what, logic [3:0] a, logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(what, reg_rdata, exp);
    endtask : reg_read

    // Offer a word until taken; check the read strobe beside the ack
    task automatic exec(logic [15:0] w, logic exp_rd, logic [11:0] exp_a);
        int n;
        @(posedge clk);
        instr <= w;
        valid <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            #1 n++;
        end while (ack !== 1'b1 && n < 8);
        check("ack", {15'h0, ack}, 16'h0001);
        check("rd", {15'h0, rd}, {15'h0, exp_rd});
        if (exp_rd)
            check("addr", {4'h0, addr}, {4'h0, exp_a});
        @(posedge clk);
        valid <= 1'b0;
        repeat (2) @(posedge clk);
        // Let the write-back edge settle before memory is peeked
        #1;
    endtask : exec

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // Watchdog, 2000 cycles, well beyond the hundred-odd cycles of the sequence
    initial
    begin
        #8000;
        error_cnt++;
        final_report();
    end

    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        reg_read("acc rst", 4'h1, 16'h0000);
        reg_read("ptr0 rst", 4'h4, 16'h0000);
        reg_read("unmapped", 4'hF, 16'h0000);
        reg_write(4'h1, 16'h009A);
        exec(16'h0935, 1'b0, 12'h000);
        reg_read("acc", 4'h1, 16'h00BF);
        reg_read("status", 4'h3, 16'h0002);
        reg_write(4'h1, 16'h0041);
        reg_write(4'h2, 16'h0003);
        exec(16'h1310, 1'b1, 12'h310);
        check("mem", {8'h0, m.mem[12'h310]}, 16'h006D);
        reg_read("acc", 4'h1, 16'h0041);
        reg_read("status", 4'h3, 16'h0000);
        exec(16'h1070, 1'b1, 12'hF70);
        reg_read("acc", 4'h1, 16'h004D);
        exec(16'h513C, 1'b1, 12'h33C);
        reg_read("acc", 4'h1, 16'h0000);
        reg_read("status", 4'h3, 16'h0001);
        reg_write(4'h0, 16'h0001);
        exec(16'hEE23, 1'b0, 12'h000);
        reg_read("ptr2 hi", 4'h6, 16'h0300);
        exec(16'hF0AB, 1'b0, 12'h000);
        reg_read("ptr2", 4'h6, 16'h03AB);
        reg_read("status", 4'h3, 16'h0001);
        exec(16'h5005, 1'b1, 12'h3B0);
        reg_read("acc", 4'h1, 16'h008C);
        exec(16'h1060, 1'b1, 12'hF60);
        reg_read("acc", 4'h1, 16'h00DC);
        exec(16'h53FF, 1'b1, 12'h3FF);
        check("mem", {8'h0, m.mem[12'h3FF]}, 16'h00C3);
        reg_read("acc", 4'h1, 16'h00DC);
        reg_read("status", 4'h3, 16'h0002);
        check("writes", 16'(wr_cnt), 16'h0002);
        final_report();
    end
endmodule : or_move_fsr_load_decode_tb
